/* File: hdl/pmp_phy.sv */
// PHY end: MII nibble paths, strap decode, negotiation outcome and management slave
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module pmp_phy
	import pmp_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	pmp_if.phy              bus,
	input  wire logic       fiberSelect,
	input  wire logic       macPortSelect,
	input  wire logic       autonegStrap,
	input  wire logic       speedStrap,
	input  wire logic       duplexStrap,
	input  wire logic [4:0] phyAddrStrap,
	input  wire logic [4:0] rxSymbol,
	input  wire logic       rxSymbolValid,
	input  wire logic [3:0] rxNibble,
	input  wire logic       pre10Confirmed,
	input  wire logic       idle10Confirmed,
	input  wire logic       flpSeen,
	input  wire logic       nlpSeen,
	input  wire logic       idle100Seen,
	input  wire logic       linkGood,
	output logic [3:0]      txNibble,
	output logic            txNibbleValid,
	output logic            flpSend,
	output logic            powerDown,
	output logic [2:0]      portMode,
	output logic            speed100,
	output logic            fullDuplex
);
	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	logic       rstSeen_q;
	logic [4:0] phyAddr_q;
	logic       fiber_q, portSel_q, aneg_q, spdStrap_q, dupStrap_q;

	always_ff @(posedge mclk) begin
		rstSeen_q <= sys_rst;
		if (rstSeen_q) begin
			phyAddr_q  <= phyAddrStrap;
			fiber_q    <= fiberSelect;
			portSel_q  <= macPortSelect;
			aneg_q     <= autonegStrap;
			spdStrap_q <= speedStrap;
			dupStrap_q <= duplexStrap;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			portMode  <= PMP_MODE_MII;
			powerDown <= 1'b0;
		end else begin
			powerDown <= (phyAddr_q == PMP_ADDR_OFF);
			if (fiber_q)
				portMode <= PMP_MODE_FX;
			else if (portSel_q)
				portMode <= PMP_MODE_MII;
			else
				portMode <= PMP_MODE_SNI;
		end
	end

	// ------------------------------------------------------------
	// Negotiation outcome
	// ------------------------------------------------------------
	logic anDone_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			speed100   <= 1'b0;
			fullDuplex <= 1'b0;
			flpSend    <= 1'b0;
			anDone_q   <= 1'b0;
		end else if (rstSeen_q) begin
			anDone_q <= 1'b0;
			flpSend  <= 1'b0;
		end else if (fiber_q) begin
			speed100   <= 1'b1;
			fullDuplex <= dupStrap_q;
		end else if (!portSel_q) begin
			speed100   <= 1'b0;
			fullDuplex <= dupStrap_q;
		end else if (!aneg_q) begin
			speed100   <= spdStrap_q;
			fullDuplex <= dupStrap_q;
		end else if (!anDone_q) begin
			flpSend <= 1'b1;
			if (flpSeen) begin
				speed100   <= spdStrap_q;
				fullDuplex <= dupStrap_q;
				anDone_q   <= 1'b1;
			end else if (nlpSeen) begin
				speed100   <= 1'b0;
				fullDuplex <= 1'b0;
				anDone_q   <= 1'b1;
			end else if (idle100Seen) begin
				speed100   <= 1'b1;
				fullDuplex <= 1'b0;
				anDone_q   <= 1'b1;
			end
		end else begin
			flpSend <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Nibble clock: 2.5 MHz by division; at 100M txc and rxc stay low and every mclk is a nibble edge
	// ------------------------------------------------------------
	logic [3:0] div_q;
	logic       clk10_q, nibEdge;

	always_ff @(posedge mclk) begin
		if (sys_rst || div_q == 4'(PMP_DIV10 - 1)) begin
			div_q <= 4'h0;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end
	always_ff @(posedge mclk) begin
		if (sys_rst)
			clk10_q <= 1'b0;
		else if (div_q == 4'(PMP_DIV10 - 1))
			clk10_q <= !clk10_q;
	end
	// Rising edge of the nibble clock; at 100M every mclk is one
	assign nibEdge = speed100 || (div_q == 4'(PMP_DIV10 - 1) && !clk10_q);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus.txc <= 1'b0;
			bus.rxc <= 1'b0;
		end else begin
			bus.txc <= speed100 ? 1'b0 : clk10_q;
			bus.rxc <= speed100 ? 1'b0 : clk10_q;
		end
	end

	// ------------------------------------------------------------
	// Transmit path; the error input is never read
	// ------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			txNibble      <= 4'h0;
			txNibbleValid <= 1'b0;
		end else begin
			txNibbleValid <= nibEdge && bus.txEn;
			if (nibEdge && bus.txEn)
				txNibble <= bus.txd;
		end
	end

	// ------------------------------------------------------------
	// Receive path
	// ------------------------------------------------------------
	logic isJK, isTR, isIdle, badSym;
	assign isJK   = rxSymbol == PMP_SYM_J || rxSymbol == PMP_SYM_K;
	assign isTR   = rxSymbol == PMP_SYM_T || rxSymbol == PMP_SYM_R;
	assign isIdle = rxSymbol == PMP_SYM_IDLE;
	assign badSym = rxSymbol[4:3] == 2'h0; // Code groups unused by 4B/5B data

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus.crs  <= 1'b0;
			bus.rxDv <= 1'b0;
			bus.rxEr <= 1'b0;
			bus.rxd  <= 4'h0;
		end else if (speed100) begin
			if (rxSymbolValid) begin
				bus.crs <= !isIdle;
				if (isJK)
					bus.rxDv <= 1'b1;
				else if (isTR || isIdle)
					bus.rxDv <= 1'b0;
				bus.rxEr <= badSym && !isTR;
				bus.rxd  <= rxNibble;
			end
		end else if (nibEdge) begin
			if (pre10Confirmed) begin
				bus.crs  <= 1'b1;
				bus.rxDv <= 1'b1;
			end else if (idle10Confirmed) begin
				bus.crs  <= 1'b0;
				bus.rxDv <= 1'b0;
			end
			bus.rxEr <= 1'b0;
			bus.rxd  <= rxNibble;
		end
	end

	// ------------------------------------------------------------
	// Management slave
	// ------------------------------------------------------------
	logic mdcS, mdioS, mdcS_q, mdcRise, mdcFall;
	pmp_sync #(.W(2)) uSync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.asyncIn ({bus.mdc, bus.mdio}),
		.syncOut ({mdcS, mdioS})
	);
	always_ff @(posedge mclk) mdcS_q <= sys_rst ? 1'b0 : mdcS;
	assign mdcRise = mdcS && !mdcS_q;
	assign mdcFall = !mdcS && mdcS_q;

	pmp_state_t  st_q;
	logic [5:0]  cnt_q;
	logic [13:0] hdr_q;
	logic [15:0] sh_q, tune2_q;
	logic        match, isRead, drive_q;
	assign match  = hdr_q[9:5] == phyAddr_q && !powerDown;
	assign isRead = hdr_q[11:10] == PMP_OP_READ;

	function automatic logic [15:0] regRead(input logic [4:0] ra);
		logic [15:0] v;
		v = 16'h0000;
		if (ra == PMP_REG_TUNE2)
			v = tune2_q;
		else if (ra == PMP_REG_TEST) begin
			v[PMP_TEST_ADLO +: PMP_ADDR_BITS] = phyAddr_q;
			v[PMP_TEST_L10]  = linkGood && !speed100;
			v[PMP_TEST_L100] = linkGood && speed100;
		end
		return v;
	endfunction : regRead

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_q    <= PMP_IDLE;
			cnt_q   <= 6'h0;
			hdr_q   <= 14'h0;
			sh_q    <= 16'h0;
			tune2_q <= PMP_TUNE2_RST;
			drive_q <= 1'b0;
		end else begin
			if (mdcRise) begin
				case (st_q)
					PMP_IDLE, PMP_PRE: begin
						if (!mdioS) begin
							st_q  <= (cnt_q >= 6'(PMP_PRE_BITS)) ? PMP_HEAD : PMP_IDLE;
							cnt_q <= 6'h0;
							hdr_q <= 14'h0;
						end else begin
							st_q <= PMP_PRE;
							if (cnt_q != 6'h3f)
								cnt_q <= cnt_q + 6'h1;
						end
					end
					PMP_HEAD: begin
						hdr_q <= {hdr_q[12:0], mdioS};
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == 6'h0 && !mdioS) begin
							st_q  <= PMP_IDLE;
							cnt_q <= 6'h0;
						end else if (cnt_q == 6'd12) begin
							st_q  <= PMP_TA;
							cnt_q <= 6'h0;
						end
					end
					PMP_TA: begin
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == 6'h1) begin
							st_q  <= PMP_DATA;
							cnt_q <= 6'h0;
						end
					end
					PMP_DATA: begin
						sh_q  <= {sh_q[14:0], mdioS};
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == 6'(PMP_DATA_BITS - 1))
							st_q <= PMP_DONE;
					end
					default: begin
						st_q  <= PMP_IDLE;
						cnt_q <= mdioS ? 6'h1 : 6'h0;
					end
				endcase
			end
			if (st_q == PMP_DONE) begin
				cnt_q <= 6'h0;
				st_q  <= PMP_IDLE;
				if (match && hdr_q[11:10] == PMP_OP_WRITE && hdr_q[4:0] == PMP_REG_TUNE2)
					tune2_q <= sh_q;
			end
			// Drive enable and read data load change only after the falling edge, so they are stable at rise
			if (mdcFall) begin
				if (st_q == PMP_TA && cnt_q == 6'h1 && match && isRead) begin
					drive_q <= 1'b1;
					sh_q    <= regRead(hdr_q[4:0]);
				end else if (st_q != PMP_DATA || !match || !isRead) begin
					drive_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			bus.mdioPhyO   <= 1'b1;
			bus.mdioPhyOeN <= 1'b1;
		end else begin
			bus.mdioPhyOeN <= !drive_q;
			bus.mdioPhyO   <= (st_q == PMP_TA) ? 1'b0 : sh_q[15];
		end
	end
endmodule : pmp_phy

/* File: hdl/pmp_pkg.sv */
// Package of constants and types shared by both ends of the PHY management/MII link
// Contract
// - Fiber and port-select straps choose medium and interface
// - Nibble clock 25MHz at 100M, 2.5MHz at 10M; code holds txc and rxc low at 100M
// - MAC drives txEn with nibbles; PHY samples on txc
// - PHY asserts receive indication, nibbles timed by rxc
// - 100M: CRS high while symbol is not IDLE
// - 10M: CRS follows confirmed preamble until idle
// - RXDV on J/K, drops on T/R/IDLE; 10M follows CRS
// - RXER high on any 5B decode error; code flags only symbols whose top two bits are 00, R excepted
// - Transmit error input is ignored
// - Five strap bits latched at reset as address
// - Address zero puts the device in power down
// - Master sends 32 ones preamble with clocks
// - Start pattern 01 begins every frame
// - Opcode 10 reads, 01 writes
// - Frame acted on only when address matches
// - Five-bit register field picks one of 32
// - Read turnaround: release, then device drives zero
// - Sixteen data bits, device on reads, master writes
// - Nobody drives the line between frames
// - Autoneg: FLP continues, NLP 10 half, idle 100 half
// - Autoneg strap: straps advertise, else force mode
// - Test register shows address and link bits
package pmp_pkg;
	localparam int          PMP_PRE_BITS   = 32;
	localparam int          PMP_DATA_BITS  = 16;
	localparam int          PMP_ADDR_BITS  = 5;
	localparam logic [1:0]  PMP_START      = 2'h1;
	localparam logic [1:0]  PMP_OP_READ    = 2'h2;
	localparam logic [1:0]  PMP_OP_WRITE   = 2'h1;
	localparam logic [4:0]  PMP_REG_TUNE2  = 5'h18;
	localparam logic [4:0]  PMP_REG_TEST   = 5'h19;
	localparam logic [4:0]  PMP_ADDR_OFF   = 5'h00;
	localparam int          PMP_TEST_ADLO  = 8;
	localparam int          PMP_TEST_L10   = 1;
	localparam int          PMP_TEST_L100  = 0;
	localparam logic [15:0] PMP_TUNE2_RST  = 16'h0000;
	// Clock rates for nibble and management clocks, in Hz
	localparam int          PMP_MCLK_HZ    = 25000000;
	localparam int          PMP_NIB100_HZ  = 25000000;
	localparam int          PMP_NIB10_HZ   = 2500000;
	localparam int          PMP_MDC_HZ     = 2500000;
	localparam int          PMP_DIV10      = PMP_MCLK_HZ / PMP_NIB10_HZ / 2;
	localparam int          PMP_DIVMDC     = PMP_MCLK_HZ / PMP_MDC_HZ / 2;
	// 5B receive symbols, after code-group alignment
	localparam logic [4:0]  PMP_SYM_IDLE   = 5'h1f;
	localparam logic [4:0]  PMP_SYM_J      = 5'h18;
	localparam logic [4:0]  PMP_SYM_K      = 5'h11;
	localparam logic [4:0]  PMP_SYM_T      = 5'h0d;
	localparam logic [4:0]  PMP_SYM_R      = 5'h07;
	// Host command register offsets
	localparam logic [1:0]  PMP_HREG_CMD   = 2'h0;
	localparam logic [1:0]  PMP_HREG_WDATA = 2'h1;
	localparam logic [1:0]  PMP_HREG_STAT  = 2'h2;
	localparam logic [1:0]  PMP_HREG_RDATA = 2'h3;

	typedef enum logic [5:0] {
		PMP_IDLE  = 6'h01,
		PMP_PRE   = 6'h02,
		PMP_HEAD  = 6'h04,
		PMP_TA    = 6'h08,
		PMP_DATA  = 6'h10,
		PMP_DONE  = 6'h20
	} pmp_state_t;

	typedef enum logic [2:0] {
		PMP_MODE_MII  = 3'h1,
		PMP_MODE_SNI  = 3'h2,
		PMP_MODE_FX   = 3'h4
	} pmp_mode_t;
endpackage : pmp_pkg

/* File: hdl/pmp_if.sv */
// Interface joining the PHY and MAC ends: MII data and management lines
`timescale 1ns/1ps
interface pmp_if;
	logic       txc;
	logic       txEn;
	logic [3:0] txd;
	logic       txEr;
	logic       rxc;
	logic       rxDv;
	logic [3:0] rxd;
	logic       rxEr;
	logic       crs;
	logic       mdc;
	logic       mdioPhyO;
	logic       mdioPhyOeN;
	logic       mdioMacO;
	logic       mdioMacOeN;
	wire        mdio;

	// Open line with pull-up: low only when an enabled driver drives zero
	assign mdio = !((!mdioPhyOeN && !mdioPhyO) || (!mdioMacOeN && !mdioMacO));

	modport phy (
		output txc, rxc, rxDv, rxd, rxEr, crs, mdioPhyO, mdioPhyOeN,
		input  txEn, txd, txEr, mdc, mdio
	);
	modport mac (
		input  txc, rxc, rxDv, rxd, rxEr, crs, mdio,
		output txEn, txd, txEr, mdc, mdioMacO, mdioMacOeN
	);
endinterface : pmp_if

/* File: hdl/pmp_sync.sv */
// Two-flop synchroniser for levels entering the mclk domain
`timescale 1ns/1ps
module pmp_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] syncOut
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule : pmp_sync

/* File: hdl/pmp_mac.sv */
// MAC end: transmit nibbles, receive capture, management master with host registers
`timescale 1ns/1ps
module pmp_mac
	import pmp_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	pmp_if.mac               bus,
	input  wire logic [1:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [31:0]      regRdata,
	input  wire logic        txReq,
	input  wire logic [3:0]  txData,
	output logic             txTaken,
	output logic [3:0]       rxData,
	output logic             rxValid,
	output logic             rxError
);
	// ------------------------------------------------------------
	// Nibble links, sampled through synchronisers
	// ------------------------------------------------------------
	logic       txcS, txcS_q, rxcS, rxcS_q, dvS, erS;
	logic [3:0] rxdS;
	pmp_sync #(.W(8)) uSync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.asyncIn ({bus.txc, bus.rxc, bus.rxDv, bus.rxEr, bus.rxd}),
		.syncOut ({txcS, rxcS, dvS, erS, rxdS})
	);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			txcS_q   <= 1'b0;
			rxcS_q   <= 1'b0;
			bus.txEn <= 1'b0;
			bus.txd  <= 4'h0;
			bus.txEr <= 1'b0;
			txTaken  <= 1'b0;
			rxData   <= 4'h0;
			rxValid  <= 1'b0;
			rxError  <= 1'b0;
		end else begin
			txcS_q  <= txcS;
			rxcS_q  <= rxcS;
			txTaken <= 1'b0;
			// Update on the falling nibble clock so data is settled at the rise
			if (!txcS && txcS_q) begin
				bus.txEn <= txReq;
				bus.txd  <= txData;
				txTaken  <= txReq;
			end
			rxValid <= 1'b0;
			if (rxcS && !rxcS_q) begin
				rxValid <= dvS;
				rxData  <= rxdS;
				rxError <= erS;
			end
		end
	end

	// ------------------------------------------------------------
	// Host registers
	// ------------------------------------------------------------
	logic        busy_q, rdOk_q, taOk_q;
	logic [4:0]  phyA_q, regA_q;
	logic        opRd_q;
	logic [15:0] wd_q, rd_q;

	always_ff @(posedge mclk) begin
		if (sys_rst)
			regRdata <= 32'h0;
		else if (!regRd)
			regRdata <= 32'h0;
		else if (regAddr == PMP_HREG_CMD)
			regRdata <= {20'h0, opRd_q, phyA_q, regA_q, 1'b0};
		else if (regAddr == PMP_HREG_WDATA)
			regRdata <= {16'h0, wd_q};
		else if (regAddr == PMP_HREG_STAT)
			regRdata <= {30'h0, rdOk_q, busy_q};
		else
			regRdata <= {16'h0, rd_q};
	end

	// ------------------------------------------------------------
	// Management master: MDC by division of mclk
	// ------------------------------------------------------------
	logic [3:0]  div_q;
	logic [6:0]  bit_q;
	logic [63:0] frm_q;
	logic        tick, go;
	assign tick = div_q == 4'(PMP_DIVMDC - 1);
	assign go   = regWr && regAddr == PMP_HREG_CMD && regWdata[0] && !busy_q;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			div_q          <= 4'h0;
			bus.mdc        <= 1'b0;
			bus.mdioMacO   <= 1'b1;
			bus.mdioMacOeN <= 1'b1;
			busy_q         <= 1'b0;
			rdOk_q         <= 1'b0;
			taOk_q         <= 1'b0;
			bit_q          <= 7'h0;
			frm_q          <= 64'h0;
			phyA_q         <= 5'h0;
			regA_q         <= 5'h0;
			opRd_q         <= 1'b0;
			wd_q           <= 16'h0;
			rd_q           <= 16'h0;
		end else begin
			div_q <= (tick || !busy_q) ? 4'h0 : div_q + 4'h1;
			if (regWr && regAddr == PMP_HREG_WDATA && !busy_q)
				wd_q <= regWdata[15:0];
			if (go) begin
				{opRd_q, phyA_q, regA_q} <= regWdata[11:1];
				busy_q <= 1'b1;
				rdOk_q <= 1'b0;
				bit_q  <= 7'h0;
				frm_q  <= {32'hffffffff, PMP_START,
					regWdata[11] ? PMP_OP_READ : PMP_OP_WRITE,
					regWdata[10:1], 2'h2, wd_q};
			end else if (busy_q && tick) begin
				bus.mdc <= !bus.mdc;
				if (bus.mdc) begin
					// Falling MDC: present next bit, released in read turnaround/data;
					// the frame closes on the fall after the last data bit's rise
					bus.mdioMacO   <= frm_q[63];
					bus.mdioMacOeN <= (opRd_q && bit_q >= 7'd47) || bit_q == 7'd65;
					frm_q          <= {frm_q[62:0], 1'b1};
					if (bit_q == 7'd65) begin
						busy_q <= 1'b0;
						rdOk_q <= opRd_q && taOk_q;
					end
				end else begin
					if (opRd_q && bit_q >= 7'd48)
						rd_q <= {rd_q[14:0], bus.mdio};
					// No device answered unless the second turnaround bit is low
					if (bit_q == 7'd48)
						taOk_q <= !bus.mdio;
					bit_q <= bit_q + 7'h1;
				end
			end
		end
	end
endmodule : pmp_mac

/* File: tb/pmp_properties.sv */
// Concurrent checks on the lines between the PHY and MAC ends
`timescale 1ns/1ps
module pmp_properties (
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic       txc,
	input wire logic       txEn,
	input wire logic [3:0] txd,
	input wire logic       rxDv,
	input wire logic       crs,
	input wire logic       mdc,
	input wire logic       mdioPhyO,
	input wire logic       mdioPhyOeN,
	input wire logic       mdioMacOeN
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	// ---------------------------------------------
	// Helper: length of one PHY drive span
	// ---------------------------------------------
	logic [7:0] drvCnt_q;
	always_ff @(posedge mclk) begin
		if (sys_rst || mdioPhyOeN)
			drvCnt_q <= 8'h00;
		else if (drvCnt_q != 8'hff)
			drvCnt_q <= drvCnt_q + 8'h01;
	end

	// Half period of the management clock is five system clocks
	sequence mdcHighRun;
		mdc [*5] ##1 !mdc;
	endsequence
	sequence taZeroBit;
		!mdioPhyO && mdioMacOeN;
	endsequence

	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	mdc_high_width_a : assert property ($rose(mdc) |-> mdcHighRun)
		else $error("management clock high phase has wrong length");
	no_contention_a : assert property (!(!mdioPhyOeN && !mdioMacOeN))
		else $error("both ends drive the management line");
	ta_zero_a : assert property ($fell(mdioPhyOeN) |-> taZeroBit)
		else $error("read turnaround does not start with a zero");
	phy_hold_a : assert property ($rose(mdc) |-> $stable({mdioPhyO, mdioPhyOeN}) [*2])
		else $error("device changed the line at the rising management clock");
	read_span_a : assert property ($rose(mdioPhyOeN) |-> drvCnt_q inside {[160:185]})
		else $error("device drive span is not seventeen bits");
	idle_release_a : assert property ($fell(sys_rst) |-> mdioPhyOeN && mdioMacOeN)
		else $error("line driven after reset");
	txd_hold_a : assert property (txc && $past(txc) |-> $stable({txEn, txd}))
		else $error("transmit nibble moved while transmit clock high");
	dv_in_crs_a : assert property (rxDv |-> crs)
		else $error("receive valid without carrier");
endmodule : pmp_properties

/* File: tb/phy_mii_management_port_bench.sv */
// Self-checking bench joining the PHY and MAC ends
`timescale 1ns/1ps
module phy_mii_management_port_bench
	import pmp_pkg::*;
;
	logic        mclk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        fiberSelect = 1'b0, macPortSelect = 1'b1, autonegStrap = 1'b0;
	logic        speedStrap = 1'b0, duplexStrap = 1'b1, rxSymbolValid = 1'b0;
	logic        pre10Confirmed = 1'b0, idle10Confirmed = 1'b1, flpSeen = 1'b0;
	logic        nlpSeen = 1'b0, idle100Seen = 1'b0, linkGood = 1'b1;
	logic        regWr = 1'b0, regRd = 1'b0, txReq = 1'b0;
	logic [4:0]  phyAddrStrap = 5'h0b, rxSymbol = 5'h1f;
	logic [3:0]  rxNibble = 4'h0, txData = 4'h0, txNibble, rxData;
	logic [1:0]  regAddr = 2'h0;
	logic [31:0] regWdata = 32'h0, regRdata, rv, st;
	logic        txNibbleValid, flpSend, powerDown, speed100, fullDuplex;
	logic        txTaken, rxValid, rxError;
	logic [2:0]  portMode;
	int          failures = 0, checked = 0;

	pmp_if pi();
	pmp_phy pmp_phy_inst (.mclk, .sys_rst, .bus(pi), .fiberSelect, .macPortSelect,
		.autonegStrap, .speedStrap, .duplexStrap, .phyAddrStrap, .rxSymbol, .rxSymbolValid,
		.rxNibble, .pre10Confirmed, .idle10Confirmed, .flpSeen, .nlpSeen, .idle100Seen,
		.linkGood, .txNibble, .txNibbleValid, .flpSend, .powerDown, .portMode, .speed100,
		.fullDuplex);
	pmp_mac pmp_mac_inst (.mclk, .sys_rst, .bus(pi), .regAddr, .regWdata, .regWr, .regRd,
		.regRdata, .txReq, .txData, .txTaken, .rxData, .rxValid, .rxError);
	pmp_properties props_inst (.mclk, .sys_rst, .txc(pi.txc), .txEn(pi.txEn), .txd(pi.txd),
		.rxDv(pi.rxDv), .crs(pi.crs), .mdc(pi.mdc), .mdioPhyO(pi.mdioPhyO),
		.mdioPhyOeN(pi.mdioPhyOeN), .mdioMacOeN(pi.mdioMacOeN));

	initial forever #20 mclk = ~mclk;

	// ---------------------------------------------
	// Shared tasks
	// ---------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rst(input logic f, m, a, s, d, input logic [4:0] ad);
		fiberSelect <= f;
		macPortSelect <= m;
		autonegStrap <= a;
		speedStrap <= s;
		duplexStrap <= d;
		phyAddrStrap <= ad;
		sys_rst <= 1'b1;
		tick(16);
		sys_rst <= 1'b0;
		tick(3);
	endtask : rst
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		tick(1);
		regWr <= 1'b0;
		tick(1);
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [31:0] d);
		regAddr <= a;
		regRd <= 1'b1;
		tick(1);
		regRd <= 1'b0;
		#1 d = regRdata;
		tick(1);
	endtask : rd
	// Polls busy with a bound so a lost frame cannot hang the run
	task automatic mgmt(input logic rdOp, input logic [4:0] ph, rg, input logic [15:0] wd);
		wr(PMP_HREG_WDATA, {16'h0, wd});
		wr(PMP_HREG_CMD, {20'h0, rdOp, ph, rg, 1'b1});
		tick(4);
		st = 32'h1;
		for (int i = 0; i < 3000 && st[0]; i++) rd(PMP_HREG_STAT, st);
		chk("busy", 32'h0, {31'h0, st[0]});
		rd(PMP_HREG_RDATA, rv);
	endtask : mgmt
	task automatic sym(input logic [4:0] s);
		rxSymbol <= s;
		rxSymbolValid <= 1'b1;
		tick(1);
		rxSymbolValid <= 1'b0;
		tick(2);
	endtask : sym

	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task automatic t_mgmt;
		mgmt(1'b0, 5'h0b, PMP_REG_TUNE2, 16'ha5c3);
		mgmt(1'b1, 5'h0b, PMP_REG_TUNE2, 16'h0);
		chk("tune2", 32'ha5c3, {16'h0, rv[15:0]});
		chk("read ok", 32'h1, {31'h0, st[1]});
		mgmt(1'b1, 5'h0b, PMP_REG_TEST, 16'h0);
		chk("test addr", 32'h0b, {27'h0, rv[12:8]});
		chk("test link", 32'h2, {30'h0, rv[1:0]});
		mgmt(1'b1, 5'h0b, 5'h03, 16'h0);
		chk("other reg", 32'h0, {16'h0, rv[15:0]});
		mgmt(1'b1, 5'h0c, PMP_REG_TEST, 16'h0);
		chk("foreign addr", 32'h0, {31'h0, st[1]});
		chk("foreign data", 32'hffff, {16'h0, rv[15:0]});
	endtask : t_mgmt
	task automatic t_tx;
		int n;
		txData <= 4'h9;
		txReq <= 1'b1;
		for (int i = 0; i < 100 && !txTaken; i++) tick(1);
		txReq <= 1'b0;
		for (int i = 0; i < 100 && !txNibbleValid; i++) tick(1);
		chk("tx nibble", 32'h9, {28'h0, txNibble});
		for (int i = 0; i < 50 && !pi.txc; i++) tick(1);
		for (int i = 0; i < 50 && pi.txc; i++) tick(1);
		n = 0;
		while (n < 50 && !pi.txc) begin
			tick(1);
			n++;
		end
		while (n < 50 && pi.txc) begin
			tick(1);
			n++;
		end
		chk("txc period", 2 * PMP_DIV10, n);
	endtask : t_tx
	task automatic t_rx10;
		rxNibble <= 4'h6;
		idle10Confirmed <= 1'b0;
		pre10Confirmed <= 1'b1;
		for (int i = 0; i < 100 && !rxValid; i++) tick(1);
		chk("rx nibble", 32'h6, {28'h0, rxData});
		chk("rx10 busy", 32'h3, {30'h0, pi.crs, pi.rxDv});
		chk("rx error", 32'h0, {31'h0, rxError});
		pre10Confirmed <= 1'b0;
		idle10Confirmed <= 1'b1;
		tick(40);
		chk("rx10 idle", 32'h0, {30'h0, pi.crs, pi.rxDv});
	endtask : t_rx10
	task automatic t_rx100;
		sym(PMP_SYM_IDLE);
		chk("rx idle", 32'h0, {29'h0, pi.crs, pi.rxDv, pi.rxEr});
		sym(PMP_SYM_J);
		sym(PMP_SYM_K);
		chk("rx start", 32'h6, {29'h0, pi.crs, pi.rxDv, pi.rxEr});
		sym(5'h03);
		chk("rx bad", 32'h7, {29'h0, pi.crs, pi.rxDv, pi.rxEr});
		sym(PMP_SYM_T);
		sym(PMP_SYM_R);
		chk("rx end", 32'h2, {30'h0, pi.crs, pi.rxDv});
		sym(PMP_SYM_IDLE);
		chk("rx back idle", 32'h0, {30'h0, pi.crs, pi.rxDv});
	endtask : t_rx100
	task automatic t_modes;
		rst(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 5'h0b);
		chk("sni", PMP_MODE_SNI, portMode);
		rst(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 5'h00);
		chk("fiber", PMP_MODE_FX, portMode);
		chk("pdown", 32'h1, powerDown);
		rst(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 5'h0b);
		chk("flp", 32'h1, flpSend);
		nlpSeen <= 1'b1;
		tick(20);
		chk("nlp fall", 32'h0, {speed100, fullDuplex});
		nlpSeen <= 1'b0;
		rst(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 5'h0b);
		idle100Seen <= 1'b1;
		tick(20);
		chk("idle fall", 32'h2, {speed100, fullDuplex});
		idle100Seen <= 1'b0;
		rst(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 5'h0b);
		flpSeen <= 1'b1;
		tick(20);
		chk("flp goes on", 32'h1, {speed100, fullDuplex});
		flpSeen <= 1'b0;
	endtask : t_modes

	task automatic results;
		$display("failures %0d checked %0d", failures, checked);
		if (failures == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results

	initial begin
		rst(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 5'h0b);
		chk("mii", PMP_MODE_MII, portMode);
		chk("forced 10 full", 32'h1, {speed100, fullDuplex});
		chk("awake", 32'h0, powerDown);
		t_mgmt;
		t_tx;
		t_rx10;
		rst(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 5'h0b);
		chk("forced 100 full", 32'h3, {speed100, fullDuplex});
		t_rx100;
		t_modes;
		results;
	end

	// Frames take under a thousand cycles each, so this leaves ample margin
	initial begin
		tick(60000);
		failures++;
		results;
	end
endmodule : phy_mii_management_port_bench
